//--- hdl/etp_cfg.svh
/* Offsets, status word fields, vector numbers and bus codes of the unit.
   Assumes one inclusion per compile unit. */
`ifndef ETP_CFG_SVH
`define ETP_CFG_SVH
`define ETP_REG_SW     8'h00
`define ETP_REG_STATE  8'h04
`define ETP_REG_FADDR  8'h08
`define ETP_REG_FINFO  8'h0C
`define ETP_SW_TRACE   15
`define ETP_SW_SUPER   13
`define ETP_SW_MASK_HI 10
`define ETP_SW_MASK_LO 8
`define ETP_SW_RESET   16'h2700
`define ETP_VEC_RESET  8'h00
`define ETP_VEC_BUS    8'h02
`define ETP_VEC_ADDR   8'h03
`define ETP_VEC_ILL    8'h04
`define ETP_VEC_ZDIV   8'h05
`define ETP_VEC_CHK    8'h06
`define ETP_VEC_OVERFLOW_TRAP_OP  8'h07
`define ETP_VEC_PRIV   8'h08
`define ETP_VEC_TRACE  8'h09
`define ETP_VEC_LINE_A 8'h0A
`define ETP_VEC_LINE_F 8'h0B
`define ETP_VEC_SPUR   8'h18
`define ETP_VEC_AUTO   8'h18
`define ETP_VEC_TRAP   8'h20
`define ETP_OP_LINE_A  4'hA
`define ETP_OP_LINE_F  4'hF
`define ETP_FC_SUP_PRG 3'h6
`define ETP_IPL_NMI    3'h7
`define ETP_PC_ADVANCE 24'h000002
`endif

//--- hdl/etp_pkg.sv
/* Sequencer states and the bundles shared with the core and bus logic.
   Assumes one processor clock for all of them. */
package etp_pkg;
    typedef enum logic [2:0] {
        st_normal = 3'b000,
        st_g0     = 3'b001,
        st_g1     = 3'b010,
        st_g2     = 3'b011,
        st_iack   = 3'b100,
        st_halt   = 3'b101
    } etp_state_type;

    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
        logic        read;
        logic        wide;
        logic        instr;
        logic [2:0]  fc;
    } etp_access_type;

    typedef struct packed {
        logic       trap_op;
        logic [3:0] trap_num;
        logic       overflow_trap_op;
        logic       overflow;
        logic       bounds_check_op;
        logic       out_of_bounds;
        logic       signed_divide_op;
        logic       unsigned_divide_op;
        logic       divisor_zero;
    } etp_g2_type;

    typedef struct packed {
        logic legal;
        logic stop_op;
        logic reset_op;
        logic return_from_exception_op;
        logic move_to_status_op;
        logic logic_imm_to_status_op;
        logic user_stack_pointer_move_op;
    } etp_decode_type;

    typedef struct packed {
        logic        start;
        logic [1:0]  group;
        logic [7:0]  vector;
        logic [23:0] vector_addr;
        logic [2:0]  fc;
    } etp_exc_type;

    typedef struct packed {
        logic        long_frame;
        logic [15:0] saved_sw;
        logic [23:0] saved_pc;
        logic [15:0] opcode;
        logic [23:0] fault_addr;
        logic        read;
        logic        not_instr;
        logic [2:0]  fc;
    } etp_frame_type;
endpackage

//--- hdl/etp_unit.sv
/* Exception sequencer: traps, trace, interrupts, faults, frame, double-fault halt.
   Assumes the core stalls on exc_busy and pulses instr_start, instr_done, exc_done. */
// Local design decisions: the strobed register port and the register offsets.
`include "etp_cfg.svh"

module etp_unit (
    // Clock and reset
    input  logic                   core_clk,
    input  logic                   rst_b,
    // Register port
    input  logic [7:0]             reg_addr,
    input  logic [31:0]            reg_wdata,
    input  logic                   reg_we,
    input  logic                   reg_re,
    output logic [31:0]            reg_rdata,
    // Instruction core
    input  logic                   instr_start,
    input  logic [15:0]            instr_opcode,
    input  logic [23:0]            instr_pc,
    input  etp_pkg::etp_decode_type instr_decode,
    input  logic                   instr_done,
    input  etp_pkg::etp_g2_type    instr_g2,
    input  logic [23:0]            next_pc,
    input  logic                   exc_done,
    output logic                   exc_busy,
    output etp_pkg::etp_exc_type   exc,
    output etp_pkg::etp_frame_type frame,
    output logic [15:0]            status_word,
    output logic                   halted,
    // Bus interface
    input  etp_pkg::etp_access_type access,
    input  logic                   bus_fault_n,
    input  logic                   transfer_acknowledge_n,
    input  logic                   sync_peripheral_select_n,
    input  logic [15:0]            data_in,
    input  logic [2:0]             ipl,
    output logic                   abort_cycle,
    output logic                   short_cycle,
    output logic                   iack_cycle,
    output logic [2:0]             iack_level,
    output logic                   upper_strobe,
    output logic                   lower_strobe
);
    etp_pkg::etp_state_type state_r;
    etp_pkg::etp_state_type state_nxt;
    logic [15:0] sw_r;
    logic [15:0] opcode_r;
    logic [23:0] pc_r;
    logic [2:0]  ipl_prev_r;
    logic [2:0]  iack_level_r;
    logic [7:0]  g2_vec_r;
    logic [31:0] rdata_r;
    logic        reset_pend_r;
    logic        in_instr_r;
    logic        trace_armed_r;
    logic        trace_pend_r;
    logic        g2_pend_r;
    logic        nmi_pend_r;
    logic        bus_err;
    logic        addr_err;
    logic        int_want;
    logic        nmi_edge;
    logic        launch;
    logic [7:0]  launch_vec;
    logic [1:0]  launch_grp;
    logic        launch_fault;
    logic        take_int;
    logic        accept_instr;
    logic        end_instr;
    logic        fire_trace;
    logic [23:0] launch_pc;
    logic [8:0]  class_hit;
    logic [8:0]  g2_hit;

    // Bit 8 marks a hit, bits 7:0 carry the vector number
    function automatic logic [8:0] etp_classify(input logic [15:0] op,
                                                input etp_pkg::etp_decode_type dec,
                                                input logic user);
        logic priv;
        priv = dec.stop_op | dec.reset_op | dec.return_from_exception_op | dec.move_to_status_op
             | dec.logic_imm_to_status_op | dec.user_stack_pointer_move_op;
        if (op[15:12] == `ETP_OP_LINE_A) begin
            etp_classify = {1'b1, `ETP_VEC_LINE_A};
        end else if (op[15:12] == `ETP_OP_LINE_F) begin
            etp_classify = {1'b1, `ETP_VEC_LINE_F};
        end else if (!dec.legal) begin
            etp_classify = {1'b1, `ETP_VEC_ILL};
        end else if (user && priv) begin
            etp_classify = {1'b1, `ETP_VEC_PRIV};
        end else begin
            etp_classify = 9'h000;
        end
    endfunction

    function automatic logic [8:0] etp_g2_vector(input etp_pkg::etp_g2_type g);
        if (g.trap_op) begin
            etp_g2_vector = {1'b1, `ETP_VEC_TRAP + {4'h0, g.trap_num}};
        end else if (g.overflow_trap_op && g.overflow) begin
            etp_g2_vector = {1'b1, `ETP_VEC_OVERFLOW_TRAP_OP};
        end else if (g.bounds_check_op && g.out_of_bounds) begin
            etp_g2_vector = {1'b1, `ETP_VEC_CHK};
        end else if ((g.signed_divide_op || g.unsigned_divide_op) && g.divisor_zero) begin
            etp_g2_vector = {1'b1, `ETP_VEC_ZDIV};
        end else begin
            etp_g2_vector = 9'h000;
        end
    endfunction

    function automatic logic [23:0] etp_vec_addr(input logic [7:0] vec);
        etp_vec_addr = {14'h0000, vec, 2'b00};
    endfunction

    // A fault seen while acknowledging is a spurious interrupt, not a bus error
    assign bus_err  = !bus_fault_n && state_r != etp_pkg::st_iack && state_r != etp_pkg::st_halt;
    assign addr_err = access.valid && access.addr[0] && (access.wide || access.instr)
                   && state_r != etp_pkg::st_halt;
    assign abort_cycle = bus_err || addr_err;
    // Outside halt, odd word and instruction accesses never reach the data phase
    assign short_cycle = addr_err;
    assign iack_cycle  = state_r == etp_pkg::st_iack;
    assign upper_strobe = iack_cycle;
    assign lower_strobe = iack_cycle;
    assign nmi_edge = ipl == `ETP_IPL_NMI && ipl_prev_r != `ETP_IPL_NMI;
    assign int_want = ipl != 3'h0
                   && (ipl > sw_r[`ETP_SW_MASK_HI:`ETP_SW_MASK_LO] || nmi_pend_r);
    assign class_hit = etp_classify(instr_opcode, instr_decode, !sw_r[`ETP_SW_SUPER]);
    assign g2_hit = g2_pend_r ? {1'b1, g2_vec_r} : etp_g2_vector(instr_g2);

    always_comb begin
        state_nxt    = state_r;
        launch       = 1'b0;
        launch_vec   = 8'h00;
        launch_grp   = 2'h0;
        launch_fault = 1'b0;
        launch_pc    = next_pc;
        take_int     = 1'b0;
        accept_instr = 1'b0;
        end_instr    = 1'b0;
        fire_trace   = 1'b0;
        if (state_r == etp_pkg::st_halt) begin
            state_nxt = etp_pkg::st_halt;
        end else if (reset_pend_r) begin
            launch     = 1'b1;
            launch_vec = `ETP_VEC_RESET;
            state_nxt  = etp_pkg::st_g0;
        end else if (bus_err || addr_err) begin
            if (state_r == etp_pkg::st_g0) begin
                state_nxt = etp_pkg::st_halt;
            end else begin
                launch       = 1'b1;
                launch_fault = 1'b1;
                launch_vec   = bus_err ? `ETP_VEC_BUS : `ETP_VEC_ADDR;
                launch_pc    = pc_r + `ETP_PC_ADVANCE;
                state_nxt    = etp_pkg::st_g0;
            end
        end else begin
            case (state_r)
                etp_pkg::st_normal: begin
                    end_instr = in_instr_r && instr_done;
                    if (end_instr && g2_hit[8]) begin
                        launch     = 1'b1;
                        launch_vec = g2_hit[7:0];
                        launch_grp = 2'h2;
                        state_nxt  = etp_pkg::st_g2;
                    end else if ((end_instr && trace_armed_r) || (!in_instr_r && trace_pend_r)) begin
                        launch     = 1'b1;
                        fire_trace = 1'b1;
                        launch_vec = `ETP_VEC_TRACE;
                        launch_grp = 2'h1;
                        state_nxt  = etp_pkg::st_g1;
                    end else if (!in_instr_r && int_want) begin
                        // A start in this cycle is dropped: the interrupt wins
                        take_int  = 1'b1;
                        state_nxt = etp_pkg::st_iack;
                    end else if (!in_instr_r && instr_start && class_hit[8]) begin
                        launch     = 1'b1;
                        launch_vec = class_hit[7:0];
                        launch_grp = 2'h1;
                        launch_pc  = instr_pc;
                        state_nxt  = etp_pkg::st_g1;
                    end else if (!in_instr_r && instr_start) begin
                        accept_instr = 1'b1;
                    end
                end
                etp_pkg::st_iack: begin
                    launch_grp = 2'h1;
                    launch_vec = `ETP_VEC_SPUR;
                    if (!transfer_acknowledge_n) begin
                        launch_vec = data_in[7:0];
                    end else if (!sync_peripheral_select_n) begin
                        launch_vec = `ETP_VEC_AUTO + {5'h00, iack_level_r};
                    end
                    if (!transfer_acknowledge_n || !sync_peripheral_select_n || !bus_fault_n) begin
                        launch    = 1'b1;
                        state_nxt = etp_pkg::st_g1;
                    end
                end
                etp_pkg::st_g0,
                etp_pkg::st_g1,
                etp_pkg::st_g2: begin
                    if (exc_done) begin
                        state_nxt = etp_pkg::st_normal;
                    end
                end
                default: begin
                    state_nxt = etp_pkg::st_halt;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= etp_pkg::st_normal;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reset_pend_r <= 1'b1;
        end else if (launch) begin
            reset_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            in_instr_r    <= 1'b0;
            trace_armed_r <= 1'b0;
            opcode_r      <= 16'h0000;
            pc_r          <= 24'h000000;
        end else if (launch_fault || end_instr) begin
            in_instr_r    <= 1'b0;
            trace_armed_r <= 1'b0;
        end else if (accept_instr) begin
            in_instr_r    <= 1'b1;
            trace_armed_r <= sw_r[`ETP_SW_TRACE];
            opcode_r      <= instr_opcode;
            pc_r          <= instr_pc;
        end
    end

    // Forced exception first; its trace waits until the handler is entered
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            trace_pend_r <= 1'b0;
        end else if (launch_fault || fire_trace) begin
            trace_pend_r <= 1'b0;
        end else if (end_instr && g2_hit[8] && trace_armed_r) begin
            trace_pend_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            g2_pend_r <= 1'b0;
            g2_vec_r  <= 8'h00;
        end else if (launch_fault || end_instr) begin
            g2_pend_r <= 1'b0;
        end else if (in_instr_r && !g2_pend_r && g2_hit[8]) begin
            g2_pend_r <= 1'b1;
            g2_vec_r  <= g2_hit[7:0];
        end
    end

    // Edge into level seven is held until taken; a new edge beats the clear
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ipl_prev_r <= 3'h0;
            nmi_pend_r <= 1'b0;
        end else begin
            ipl_prev_r <= ipl;
            if (nmi_edge) begin
                nmi_pend_r <= 1'b1;
            end else if (take_int) begin
                nmi_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            iack_level_r <= 3'h0;
        end else if (take_int) begin
            iack_level_r <= ipl;
        end
    end

    // Hardware updates win over a software write in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sw_r <= `ETP_SW_RESET;
        end else if (reset_pend_r) begin
            sw_r <= `ETP_SW_RESET;
        end else if (take_int) begin
            sw_r[`ETP_SW_SUPER]                    <= 1'b1;
            sw_r[`ETP_SW_TRACE]                    <= 1'b0;
            sw_r[`ETP_SW_MASK_HI:`ETP_SW_MASK_LO] <= ipl;
        end else if (launch) begin
            sw_r[`ETP_SW_SUPER] <= 1'b1;
            sw_r[`ETP_SW_TRACE] <= 1'b0;
        end else if (reg_we && reg_addr == `ETP_REG_SW) begin
            sw_r <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            exc <= '0;
        end else begin
            exc.start <= launch;
            if (launch) begin
                exc.group       <= launch_grp;
                exc.vector      <= launch_vec;
                exc.vector_addr <= etp_vec_addr(launch_vec);
                exc.fc          <= `ETP_FC_SUP_PRG;
            end
        end
    end

    // Status copy is taken before acknowledge alters it
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            frame <= '0;
        end else if (take_int) begin
            frame.long_frame <= 1'b0;
            frame.saved_sw   <= sw_r;
            frame.saved_pc   <= next_pc;
        end else if (launch && !reset_pend_r) begin
            frame.long_frame <= launch_fault;
            frame.saved_pc   <= launch_pc;
            if (state_r != etp_pkg::st_iack) begin
                frame.saved_sw <= sw_r;
            end
            if (launch_fault) begin
                frame.opcode     <= opcode_r;
                frame.fault_addr <= access.addr;
                frame.read       <= access.read;
                frame.fc         <= access.fc;
                frame.not_instr  <= state_r == etp_pkg::st_g1 || state_r == etp_pkg::st_iack;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdata_r <= 32'h00000000;
        end else if (reg_re) begin
            case (reg_addr)
                `ETP_REG_SW:    rdata_r <= {16'h0000, sw_r};
                `ETP_REG_STATE: rdata_r <= {17'h00000, in_instr_r, g2_pend_r, trace_pend_r, halted,
                                            state_r, exc.vector};
                `ETP_REG_FADDR: rdata_r <= {8'h00, frame.fault_addr};
                `ETP_REG_FINFO: rdata_r <= {10'h000, frame.long_frame, frame.fc, frame.not_instr,
                                            frame.read, frame.opcode};
                default:        rdata_r <= 32'h00000000;
            endcase
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign reg_rdata   = rdata_r;
    assign status_word = sw_r;
    assign halted      = state_r == etp_pkg::st_halt;
    assign exc_busy    = state_r != etp_pkg::st_normal || reset_pend_r;
    assign iack_level  = iack_level_r;
endmodule

//--- bench/etp_unit_props.sv
/* Checker bound to etp_unit: fault, acknowledge and vector relations.
   Assumes the one core clock and the synchronous active-low reset. */
module etp_unit_props (
    // Clock and reset
    input logic                   core_clk,
    input logic                   rst_b,
    // Bus side
    input etp_pkg::etp_access_type access,
    input logic                   bus_fault_n,
    input logic                   transfer_acknowledge_n,
    input logic                   sync_peripheral_select_n,
    input logic [15:0]            data_in,
    input logic                   abort_cycle,
    input logic                   short_cycle,
    input logic                   iack_cycle,
    input logic                   upper_strobe,
    input logic                   lower_strobe,
    // Core side
    input etp_pkg::etp_exc_type   exc,
    input etp_pkg::etp_frame_type frame,
    input logic [15:0]            status_word,
    input logic                   exc_busy,
    input logic                   halted
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_flt_go;
        abort_cycle && !halted ##1 exc.start;
    endsequence
    sequence s_bus_go;
        abort_cycle && !halted && !short_cycle ##1 exc.start;
    endsequence
    sequence s_run_go;
        abort_cycle && !halted && !exc_busy ##1 exc.start;
    endsequence
    spur_vec_a: assert property (
        iack_cycle && !bus_fault_n && transfer_acknowledge_n && sync_peripheral_select_n
        |=> exc.start && exc.vector == 8'h18) else $error("spurious vector not used");
    property iact_chk;
        iack_cycle |-> upper_strobe && lower_strobe;
    endproperty
    both_strobe_a: assert property (iact_chk) else $error("byte strobes not both set");
    low_byte_a: assert property (
        iack_cycle && !transfer_acknowledge_n |=> exc.vector == $past(data_in[7:0])) else $error("vector byte wrong");
    vec_addr_a: assert property (
        exc.start |-> exc.vector_addr == {14'h0, exc.vector, 2'h0}) else $error("vector address wrong");
    odd_acc_a: assert property (
        access.valid && access.addr[0] && (access.wide || access.instr) && !halted |-> short_cycle && abort_cycle)
        else $error("odd access not cut short");
    flt_start_a: assert property (
        abort_cycle && !halted |=> (exc.start && exc.group == 2'h0) || halted) else $error("fault not started");
    flt_vec_a: assert property (
        s_bus_go |-> exc.vector == 8'h02 && frame.fault_addr == $past(access.addr)) else $error("fault frame wrong");
    flt_sw_a: assert property (
        s_flt_go |-> ##[0:1] (status_word[13] && !status_word[15])) else $error("fault status word wrong");
    flt_flag_a: assert property (
        s_run_go |-> !frame.not_instr && frame.read == $past(access.read)) else $error("fault flags wrong");
    halt_hold_a: assert property (halted |=> halted) else $error("left halt without reset");
endmodule
bind etp_unit etp_unit_props u_etp_unit_props (.*);

//--- bench/etp_bus_model.sv
/* Acknowledge responder standing for the external bus logic and devices.
   Assumes the unit holds iack_cycle until it takes an answer. */
module etp_bus_model (
    // Bench control
    input wire logic        core_clk,
    input wire logic [1:0]  mode,
    input wire logic [1:0]  delay,
    input wire logic [7:0]  vec,
    // Unit side
    input wire logic        iack_cycle,
    output logic            transfer_acknowledge_n,
    output logic            sync_peripheral_select_n,
    output logic            bus_fault_n,
    output logic [15:0]     data_in
);
    logic [1:0]  cnt_r = '0;
    logic [15:0] pat_r = 16'h1234;
    logic        go;
    logic        dat;
    always_ff @(posedge core_clk) begin
        cnt_r <= !iack_cycle ? 2'h0 : (go ? cnt_r : cnt_r + 2'h1);
        pat_r <= pat_r + 16'h3C5B;
    end
    // Idle data lines keep changing so a stale byte never passes for a vector
    assign go = iack_cycle && cnt_r == delay;
    assign dat = go && mode[0] == mode[1];
    assign transfer_acknowledge_n = !dat;
    assign sync_peripheral_select_n = !(go && mode == 2'h1);
    assign bus_fault_n = !(go && mode == 2'h2);
    assign data_in = dat ? {pat_r[15:8], mode[0] ? 8'h0F : vec} : pat_r;
endmodule

//--- bench/tb_etp_unit.sv
/* Bench for etp_unit: decode, traps, trace, acknowledge, faults.
   Assumes the responder model and the checker. */
module tb_etp_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = '0, rst_b = '0, reg_we = '0, reg_re = '0, instr_start = '0, instr_done = '0, exc_done = '0;
    logic tb_flt_n = '1, bf_m_n, bus_fault_n, exc_busy, halted, abort_cycle, short_cycle, iack_cycle, r;
    logic upper_strobe, lower_strobe, transfer_acknowledge_n, sync_peripheral_select_n;
    logic [1:0]  m_mode = '0, m_del = '0;
    logic [2:0]  ipl = '0, iack_level, lv;
    logic [7:0]  reg_addr = '0, m_vec = '0, v;
    logic [11:0] g, tab [8] = '{12'h800, 12'h060, 12'h040, 12'h018, 12'h010, 12'h005, 12'h003, 12'h004};
    logic [15:0] instr_opcode = '0, status_word, data_in;
    logic [23:0] instr_pc = '0, next_pc = 24'h001000, a;
    logic [31:0] reg_wdata = '0, reg_rdata;
    etp_pkg::etp_decode_type instr_decode = '0;
    etp_pkg::etp_g2_type     instr_g2 = '0;
    etp_pkg::etp_access_type access = '0;
    etp_pkg::etp_exc_type    exc;
    etp_pkg::etp_frame_type  frame;
    int err_total = 0, total_checks = 0, seed = 90064, i, t;

    etp_unit u_etp_unit (.*);
    etp_bus_model u_etp_bus_model (.core_clk, .mode(m_mode), .delay(m_del), .vec(m_vec), .iack_cycle,
        .transfer_acknowledge_n, .sync_peripheral_select_n, .bus_fault_n(bf_m_n), .data_in);
    assign bus_fault_n = tb_flt_n & bf_m_n;
    always #10 core_clk = ~core_clk;

    task automatic chk(input string n, input logic [79:0] e, input logic [79:0] s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [31:0] d);
        @(posedge core_clk);
        reg_we <= 1'h1;
        reg_addr <= 8'h00;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        @(posedge core_clk);
        reg_re <= 1'h1;
        reg_addr <= ad;
        @(posedge core_clk);
        reg_re <= 1'h0;
        @(negedge core_clk);
        chk("read data", e, reg_rdata);
    endtask
    // Waits for the exception start pulse, then plays the core loading the handler
    task automatic ex(input logic [7:0] ev);
        int k;
        k = 0;
        @(negedge core_clk);
        while (exc.start !== 1'h1 && k < 30) begin
            @(negedge core_clk);
            k++;
        end
        chk("vector", {1'h1, ev, 14'h0, ev, 2'h0}, {exc.start, exc.vector, exc.vector_addr});
        @(posedge core_clk);
        exc_done <= 1'h1;
        @(posedge core_clk);
        exc_done <= 1'h0;
    endtask
    task automatic idle();
        repeat (4) @(negedge core_clk);
        chk("idle", 1'h0, exc_busy);
    endtask
    task automatic rst();
        @(posedge core_clk);
        rst_b <= 1'h0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'h1;
        ex(8'h00);
    endtask
    task automatic run(input logic [15:0] op, input logic [6:0] d, input logic [11:0] gg, input logic fin,
                       input logic [2:0] il);
        @(posedge core_clk);
        instr_start <= 1'h1;
        instr_opcode <= op;
        instr_decode <= d;
        instr_g2 <= gg;
        instr_pc <= 24'($random(seed)) & 24'hFFFFFE;
        @(posedge core_clk);
        instr_start <= 1'h0;
        if (fin) begin
            @(posedge core_clk);
            instr_done <= 1'h1;
            ipl <= il;
            @(posedge core_clk);
            instr_done <= 1'h0;
            instr_g2 <= '0;
        end
    endtask
    task automatic flt(input logic [23:0] fa, input logic rw, input logic bf);
        @(posedge core_clk);
        access <= '{1'h1, fa, rw, 1'h1, 1'h0, 3'h1};
        tb_flt_n <= !bf;
        @(negedge core_clk);
        chk("abort", {1'h1, !bf}, {abort_cycle, short_cycle});
        @(posedge core_clk);
        access <= '0;
        tb_flt_n <= 1'h1;
    endtask
    function automatic logic [7:0] g2v(input logic [11:0] x);
        if (x[11]) return 8'h20 + 8'(x[10:7]);
        if (x[6] && x[5]) return 8'h07;
        if (x[4] && x[3]) return 8'h06;
        if ((x[2] || x[1]) && x[0]) return 8'h05;
        return 8'hFF;
    endfunction

    initial begin
        #400000;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'h1;
        ex(8'h00);
        chk("reset word", 16'h2700, status_word);
        wr(32'($random(seed)) & 32'h0000A700);
        rd(8'h00, reg_wdata);
        rd(8'h04, 32'h0);
        rd(8'h40, 32'h0);
        for (i = 0; i < 9; i++) begin
            wr(32'h00008000);
            v = i < 6 ? 8'h08 : (i == 6 ? 8'h04 : (i == 7 ? 8'h0A : 8'h0B));
            run({i == 7 ? 4'hA : (i == 8 ? 4'hF : 4'h4), 12'($random(seed))},
                i < 6 ? 7'h40 | (7'h01 << i) : 7'h00, '0, 1'h0, 3'h0);
            ex(v);
            idle();
        end
        for (t = 0; t < 2; t++)
            for (i = 0; i < 8; i++) begin
                wr(t ? 32'h0000A000 : 32'h00002000);
                g = i == 0 ? {1'h1, 4'($random(seed)), 7'h0} : tab[i];
                run({4'h4, 12'($random(seed))}, 7'h40, g, 1'h1, 3'h0);
                if (g2v(g) != 8'hFF) ex(g2v(g));
                if (t) ex(8'h09);
                else if (g2v(g) == 8'hFF) idle();
            end
        wr(32'h00008000);
        m_vec <= 8'h40;
        run(16'h4000, 7'h40, '0, 1'h1, 3'h3);
        ex(8'h09);
        ex(8'h40);
        ipl <= 3'h0;
        for (i = 0; i < 4; i++) begin
            wr(32'h00002000);
            lv = 3'h1 + 3'((32'($random(seed)) & 32'hFF) % 6);
            v = 8'($random(seed));
            m_vec <= v;
            m_mode <= 2'(i);
            m_del <= 2'($random(seed));
            ipl <= lv;
            ex(i == 0 ? v : (i == 1 ? 8'h18 + 8'(lv) : (i == 2 ? 8'h18 : 8'h0F)));
            chk("level", lv, iack_level);
            ipl <= 3'h0;
        end
        wr(32'h00008000);
        run({4'h4, 12'($random(seed))}, 7'h40, '0, 1'h0, 3'h0);
        a = 24'($random(seed)) & 24'hFFFFFE;
        r = 1'($random(seed));
        flt(a, r, 1'h1);
        ex(8'h02);
        chk("frame", {a, r, 1'h0, instr_pc + 24'h2, instr_opcode, 3'h1}, {frame.fault_addr, frame.read,
            frame.not_instr, frame.saved_pc, frame.opcode, frame.fc});
        chk("fault word", 2'h1, {status_word[15], status_word[13]});
        idle();
        run({4'h4, 12'($random(seed))}, 7'h40, '0, 1'h0, 3'h0);
        flt(24'($random(seed)) | 24'h000001, 1'h1, 1'h0);
        ex(8'h03);
        flt(24'h000100, 1'h0, 1'h1);
        repeat (2) @(posedge core_clk);
        flt(24'h000200, 1'h1, 1'h1);
        repeat (3) @(negedge core_clk);
        chk("halt", 2'h3, {halted, exc_busy});
        rst();
        chk("halt cleared", 1'h0, halted);
        end_sim();
    end
endmodule
